// *** src/sfr_pkg.sv ***
// shared constants and types of the core special register space
package sfr_pkg;

   // ************************************************************
   // register addresses
   // ************************************************************
   localparam logic [7:0] A_STK    = 8'h81;
   localparam logic [7:0] A_PTRLO  = 8'h82;
   localparam logic [7:0] A_PTRHI  = 8'h83;
   localparam logic [7:0] A_T0LO   = 8'h8A;
   localparam logic [7:0] A_T1LO   = 8'h8B;
   localparam logic [7:0] A_T0HI   = 8'h8C;
   localparam logic [7:0] A_T1HI   = 8'h8D;
   localparam logic [7:0] A_PORT1  = 8'h90;
   localparam logic [7:0] A_SERBUF = 8'h99;
   localparam logic [7:0] A_DRV3   = 8'h9C;
   localparam logic [7:0] A_DRV4   = 8'h9D;
   localparam logic [7:0] A_DRV5   = 8'h9E;
   localparam logic [7:0] A_UPORT  = 8'hA0;
   localparam logic [7:0] A_MISC   = 8'hA2;
   localparam logic [7:0] A_PORT3  = 8'hB0;
   localparam logic [7:0] A_PORT4  = 8'hC0;
   localparam logic [7:0] A_PORT5  = 8'hC4;
   localparam logic [7:0] A_T2LO   = 8'hCC;
   localparam logic [7:0] A_T2HI   = 8'hCD;
   localparam logic [7:0] A_STAT   = 8'hD0;
   localparam logic [7:0] A_OPA    = 8'hE0;
   localparam logic [7:0] A_OPB    = 8'hF0;
   localparam logic [7:0] A_BOOT   = 8'hF1;
   localparam logic [7:0] A_WDOG   = 8'hFF;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int POS_CARRY    = 7;
   localparam int POS_HALF     = 6;
   localparam int POS_FLAGA    = 5;
   localparam int POS_BANKHI   = 4;
   localparam int POS_BANKLO   = 3;
   localparam int POS_RANGE    = 2;
   localparam int POS_FLAGB    = 1;
   localparam int POS_PARITY   = 0;
   localparam int POS_SOFTRST  = 5;
   localparam int POS_FLAGC    = 4;
   localparam int POS_WAKEEN   = 3;
   localparam int POS_PTRSEL   = 0;
   localparam int POS_RELOAD   = 2;
   localparam int POS_WDRELOAD = 1;
   localparam int POS_RATE2    = 0;

   // ************************************************************
   // reset values and masks
   // ************************************************************
   localparam logic [7:0] STK_RST   = 8'h07;
   localparam logic [7:0] PORT_RST  = 8'hFF;
   localparam logic [7:0] MISC_MASK = 8'h39;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [3:0] {
      AM_DIRECT, AM_IND_RI, AM_IND_SP, AM_EXT_RI, AM_EXT_DP,
      AM_REG, AM_IMM, AM_IDX_DP, AM_IDX_PC, AM_JMP
   } am_mode_e;

   typedef enum logic [2:0] {
      SPC_IRAM, SPC_UPPER, SPC_SFR, SPC_XDATA, SPC_CODE, SPC_IMM
   } space_e;

   typedef struct packed {
      logic       opa_ld;
      logic [7:0] opa;
      logic       opb_ld;
      logic [7:0] opb;
      logic       flag_ld;
      logic       carry;
      logic       half;
      logic       range;
   } alu_upd_s;

   typedef struct packed {
      logic        valid;
      am_mode_e    mode;
      logic [7:0]  field;
      logic [7:0]  ptr;
      logic [15:0] pc;
   } am_req_s;

   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      space_e      space;
   } am_rsp_s;

   typedef struct packed {
      logic [7:0]       opa, opb, stat, stk, misc;
      logic [7:0]       port1, uport, wdog, rdata, tx;
      logic [1:0][15:0] ptr;
      logic [2:0][7:0]  port, mode, oe;
      logic [2:0][15:0] tmr;
      logic [1:0]       boot;
      logic             bitr, txgo, reload, wake, soft_reset_bit;
      am_rsp_s          am;
   } st_s;

endpackage

// *** src/cpu_special_register_space.sv ***
// special register space and operand addressing of the core
`timescale 1ns/1ps

module cpu_special_register_space
   import sfr_pkg::*;
(
   // clock and reset
   input  logic             CORE_CLK,
   input  logic             RESET,
   // byte access
   input  logic [7:0]       SFR_ADDR,
   input  logic             SFR_WR,
   input  logic [7:0]       SFR_WDATA,
   input  logic             SFR_RD,
   output logic [7:0]       SFR_RDATA,
   // bit access
   input  logic [7:0]       BIT_ADDR,
   input  logic             BIT_WR,
   input  logic             BIT_WVAL,
   input  logic             BIT_RD,
   output logic             BIT_RDATA,
   // core datapath
   input  alu_upd_s         ALU_UPD,
   input  logic             PTR_INC,
   output logic [7:0]       OPA_OUT,
   output logic [7:0]       OPB_OUT,
   output logic [7:0]       STAT_OUT,
   output logic [7:0]       STK_OUT,
   // operand addressing
   input  am_req_s          AM_REQ,
   output am_rsp_s          AM_RSP,
   // serial port
   input  logic [7:0]       SER_RX_DATA,
   output logic [7:0]       SER_TX_DATA,
   output logic             SER_TX_START,
   output logic             RATE_DOUBLE,
   // timers and watchdog
   input  logic [2:0]       TMR_TICK,
   input  logic             WDOG_TICK,
   input  logic             WDOG_TIMEOUT,
   output logic [2:0][15:0] TMR_COUNT,
   output logic [7:0]       WDOG_COUNT,
   // boot, power and reset
   output logic             RELOAD_REQ,
   input  logic             PD_ACTIVE,
   input  logic             EXT_IRQ,
   output logic             WAKE,
   output logic             SOFT_RESET,
   // port pins
   output logic [7:0]       PORT1_OUT,
   output logic [2:0][7:0]  PORT_OUT,
   output logic [2:0][7:0]  PORT_OE
);

   // ************************************************************
   // state and helpers
   // ************************************************************
   st_s         s_q;
   st_s         s_d;
   logic [7:0]  wa;
   logic [7:0]  wd;
   logic [7:0]  ba;
   logic [7:0]  cur;
   logic [7:0]  f;
   logic [1:0]  bank;
   logic        we;
   logic        sel;
   logic [15:0] idx_sum;

   function automatic logic [7:0] rd(input st_s s,
                                     input logic [7:0] a,
                                     input logic [7:0] rx);
      logic d;
      d = s.misc[POS_PTRSEL];
      case (a)
         A_OPA:    rd = s.opa;
         A_OPB:    rd = s.opb;
         A_STAT:   rd = s.stat;
         A_STK:    rd = s.stk;
         A_PTRLO:  rd = s.ptr[d][7:0];
         A_PTRHI:  rd = s.ptr[d][15:8];
         A_MISC:   rd = s.misc & MISC_MASK;
         A_PORT1:  rd = s.port1;
         A_UPORT:  rd = s.uport;
         A_PORT3:  rd = s.port[0];
         A_PORT4:  rd = s.port[1];
         A_PORT5:  rd = s.port[2];
         A_DRV3:   rd = s.mode[0];
         A_DRV4:   rd = s.mode[1];
         A_DRV5:   rd = s.mode[2];
         // reads see the receive side, not the transmit latch
         A_SERBUF: rd = rx;
         A_T0LO:   rd = s.tmr[0][7:0];
         A_T0HI:   rd = s.tmr[0][15:8];
         A_T1LO:   rd = s.tmr[1][7:0];
         A_T1HI:   rd = s.tmr[1][15:8];
         A_T2LO:   rd = s.tmr[2][7:0];
         A_T2HI:   rd = s.tmr[2][15:8];
         A_WDOG:   rd = s.wdog;
         A_BOOT:   rd = {6'h00, s.boot};
         default:  rd = 8'h00;
      endcase
      return rd;
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      s_d     = s_q;
      sel     = s_q.misc[POS_PTRSEL];
      bank    = s_q.stat[POS_BANKHI:POS_BANKLO];
      f       = AM_REQ.field;
      idx_sum = s_q.ptr[sel] + {8'h00, s_q.opa};
      wa      = SFR_ADDR;
      wd      = SFR_WDATA;
      we      = SFR_WR;
      ba      = {BIT_ADDR[7:3], 3'b000};
      cur     = rd(s_q, ba, SER_RX_DATA);
      s_d.txgo   = 1'b0;
      s_d.reload = 1'b0;
      s_d.soft_reset_bit   = 1'b0;

      // bit ops are read-modify-write on the byte
      if (!SFR_WR && BIT_WR && BIT_ADDR[7]) begin
         wa = ba;
         wd = cur;
         wd[BIT_ADDR[2:0]] = BIT_WVAL;
         we = 1'b1;
      end
      if (BIT_RD && BIT_ADDR[7]) begin
         s_d.bitr = cur[BIT_ADDR[2:0]];
      end
      if (SFR_RD) begin
         s_d.rdata = rd(s_q, SFR_ADDR, SER_RX_DATA);
      end

      // count first so a software write wins
      for (int i = 0; i < 3; i++) begin
         if (TMR_TICK[i]) begin
            s_d.tmr[i] = s_q.tmr[i] + 16'h0001;
         end
      end
      if (WDOG_TICK) begin
         s_d.wdog = s_q.wdog + 8'h01;
      end
      if (PTR_INC) begin
         s_d.ptr[sel] = s_q.ptr[sel] + 16'h0001;
      end

      if (we) begin
         case (wa)
            A_OPA:    s_d.opa = wd;
            A_OPB:    s_d.opb = wd;
            A_STAT:   s_d.stat = wd;
            A_STK:    s_d.stk = wd;
            A_PTRLO:  s_d.ptr[sel][7:0] = wd;
            A_PTRHI:  s_d.ptr[sel][15:8] = wd;
            A_MISC: begin
               s_d.misc = wd & MISC_MASK;
               s_d.soft_reset_bit = wd[POS_SOFTRST];
            end
            A_PORT1:  s_d.port1 = wd;
            A_UPORT:  s_d.uport = wd;
            A_PORT3:  s_d.port[0] = wd;
            A_PORT4:  s_d.port[1] = wd;
            A_PORT5:  s_d.port[2] = wd;
            A_DRV3:   s_d.mode[0] = wd;
            A_DRV4:   s_d.mode[1] = wd;
            A_DRV5:   s_d.mode[2] = wd;
            A_SERBUF: begin
               s_d.tx   = wd;
               s_d.txgo = 1'b1;
            end
            A_T0LO:   s_d.tmr[0][7:0] = wd;
            A_T0HI:   s_d.tmr[0][15:8] = wd;
            A_T1LO:   s_d.tmr[1][7:0] = wd;
            A_T1HI:   s_d.tmr[1][15:8] = wd;
            A_T2LO:   s_d.tmr[2][7:0] = wd;
            A_T2HI:   s_d.tmr[2][15:8] = wd;
            A_WDOG:   s_d.wdog = wd;
            A_BOOT: begin
               // reload bit is a request, it never reads back
               s_d.boot = wd[1:0];
               s_d.reload = wd[POS_RELOAD];
            end
            default: begin
            end
         endcase
      end

      // hardware results land after software writes
      if (ALU_UPD.opa_ld) begin
         s_d.opa = ALU_UPD.opa;
      end
      if (ALU_UPD.opb_ld) begin
         s_d.opb = ALU_UPD.opb;
      end
      if (ALU_UPD.flag_ld) begin
         s_d.stat[POS_CARRY] = ALU_UPD.carry;
         s_d.stat[POS_HALF]  = ALU_UPD.half;
         s_d.stat[POS_RANGE] = ALU_UPD.range;
      end
      s_d.stat[POS_PARITY] = ^s_d.opa;

      if (WDOG_TIMEOUT && s_q.boot[POS_WDRELOAD]) begin
         s_d.reload = 1'b1;
      end
      s_d.wake = PD_ACTIVE & EXT_IRQ & s_q.misc[POS_WAKEEN];

      // weak pull-up only drives actively when pulling low
      for (int k = 0; k < 3; k++) begin
         s_d.oe[k] = s_d.mode[k] | ~s_d.port[k];
      end

      // ************************************************************
      // operand address formation
      // ************************************************************
      s_d.am.valid = AM_REQ.valid;
      if (AM_REQ.valid) begin
         case (AM_REQ.mode)
            AM_DIRECT: begin
               s_d.am.addr  = {8'h00, f};
               s_d.am.space = f[7] ? SPC_SFR : SPC_IRAM;
            end
            AM_IND_RI: begin
               s_d.am.addr  = {8'h00, AM_REQ.ptr};
               s_d.am.space = AM_REQ.ptr[7] ? SPC_UPPER
                                            : SPC_IRAM;
            end
            AM_IND_SP: begin
               s_d.am.addr  = {8'h00, s_q.stk};
               s_d.am.space = s_q.stk[7] ? SPC_UPPER
                                         : SPC_IRAM;
            end
            AM_EXT_RI: begin
               s_d.am.addr  = {s_q.uport, AM_REQ.ptr};
               s_d.am.space = SPC_XDATA;
            end
            AM_EXT_DP: begin
               s_d.am.addr  = s_q.ptr[sel];
               s_d.am.space = SPC_XDATA;
            end
            AM_REG: begin
               s_d.am.addr  = {11'h000, bank, f[2:0]};
               s_d.am.space = SPC_IRAM;
            end
            AM_IMM: begin
               s_d.am.addr  = {8'h00, f};
               s_d.am.space = SPC_IMM;
            end
            AM_IDX_DP: begin
               s_d.am.addr  = idx_sum;
               s_d.am.space = SPC_CODE;
            end
            AM_IDX_PC: begin
               s_d.am.addr  = AM_REQ.pc + {8'h00, s_q.opa};
               s_d.am.space = SPC_CODE;
            end
            AM_JMP: begin
               s_d.am.addr  = idx_sum;
               s_d.am.space = SPC_CODE;
            end
            default: begin
               s_d.am.addr  = 16'h0000;
               s_d.am.space = SPC_IRAM;
            end
         endcase
      end
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge CORE_CLK) begin
      if (RESET || s_q.soft_reset_bit) begin
         s_q       <= '0;
         s_q.stk   <= STK_RST;
         s_q.port1 <= PORT_RST;
         s_q.uport <= PORT_RST;
         s_q.port  <= {3{PORT_RST}};
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign SFR_RDATA    = s_q.rdata;
   assign BIT_RDATA    = s_q.bitr;
   assign OPA_OUT      = s_q.opa;
   assign OPB_OUT      = s_q.opb;
   assign STAT_OUT     = s_q.stat;
   assign STK_OUT      = s_q.stk;
   assign AM_RSP       = s_q.am;
   assign SER_TX_DATA  = s_q.tx;
   assign SER_TX_START = s_q.txgo;
   assign RATE_DOUBLE  = s_q.boot[POS_RATE2];
   assign TMR_COUNT    = s_q.tmr;
   assign WDOG_COUNT   = s_q.wdog;
   assign RELOAD_REQ   = s_q.reload;
   assign WAKE         = s_q.wake;
   assign SOFT_RESET   = s_q.soft_reset_bit;
   assign PORT1_OUT    = s_q.port1;
   assign PORT_OUT     = s_q.port;
   assign PORT_OE      = s_q.oe;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);

   a_stk_reset_val :
      assert property ($fell(RESET) |-> s_q.stk == STK_RST)
      else $error("stack pointer not at reset value");

   a_parity_even :
      assert property ((^{s_q.opa, s_q.stat[POS_PARITY]}) == 1'b0)
      else $error("parity bit does not match operand A");

   a_reg_bank :
      assert property ((AM_REQ.valid && AM_REQ.mode == AM_REG
                        && !s_q.soft_reset_bit)
         |=> AM_RSP.valid
             && AM_RSP.addr == {11'h000, $past(bank), $past(f[2:0])})
      else $error("register operand not in selected bank");

   a_direct_route :
      assert property ((AM_REQ.valid && AM_REQ.mode == AM_DIRECT
                        && !s_q.soft_reset_bit)
         |=> AM_RSP.space == ($past(f[7]) ? SPC_SFR : SPC_IRAM))
      else $error("direct access routed to wrong space");

   a_ext_upper :
      assert property ((AM_REQ.valid && AM_REQ.mode == AM_EXT_RI
                        && !s_q.soft_reset_bit)
         |=> AM_RSP.addr[15:8] == $past(s_q.uport)
             && AM_RSP.space == SPC_XDATA)
      else $error("external address upper byte wrong");

   a_idx_sum :
      assert property ((AM_REQ.valid && AM_REQ.mode == AM_IDX_DP
                        && !s_q.soft_reset_bit)
         |=> AM_RSP.addr == $past(idx_sum) && AM_RSP.space == SPC_CODE)
      else $error("indexed address is not base plus A");

   a_tx_load :
      assert property ((SFR_WR && SFR_ADDR == A_SERBUF && !s_q.soft_reset_bit)
         |=> SER_TX_START && SER_TX_DATA == $past(SFR_WDATA))
      else $error("serial write did not start transmit");

   a_wake_gate :
      assert property (!s_q.misc[POS_WAKEEN] |=> !WAKE)
      else $error("wake without wake enable");

   a_wd_reload :
      assert property ((WDOG_TIMEOUT && s_q.boot[POS_WDRELOAD]
                        && !s_q.soft_reset_bit) |=> RELOAD_REQ)
      else $error("watchdog timeout did not request reload");

   a_soft_reset :
      assert property (s_q.soft_reset_bit |=> s_q.stk == STK_RST && !SOFT_RESET)
      else $error("soft reset did not restore the core");

   a_push_pull :
      assert property ((s_q.mode & ~PORT_OE) == 24'h00_0000)
      else $error("push-pull pin not driven");

   a_ptr_select :
      assert property ((SFR_WR && SFR_ADDR == A_PTRLO && !s_q.soft_reset_bit)
         |=> s_q.ptr[$past(sel)][7:0] == $past(SFR_WDATA))
      else $error("data pointer write missed selected pointer");

endmodule // cpu_special_register_space

// *** dv/tb_top.sv ***
// self-checking bench for the core special register space
`timescale 1ns/1ps

module tb_top
   import sfr_pkg::*;
;
   // ************************************************************
   // design signals
   // ************************************************************
   logic             CORE_CLK, RESET, SFR_WR, SFR_RD, BIT_WR;
   logic [7:0]       SFR_ADDR, SFR_WDATA, SFR_RDATA, BIT_ADDR;
   logic             BIT_WVAL, BIT_RD, BIT_RDATA, PTR_INC;
   alu_upd_s         ALU_UPD;
   logic [7:0]       OPA_OUT, OPB_OUT, STAT_OUT, STK_OUT;
   am_req_s          AM_REQ;
   am_rsp_s          AM_RSP;
   logic [7:0]       SER_RX_DATA, SER_TX_DATA, WDOG_COUNT, PORT1_OUT;
   logic             SER_TX_START, RATE_DOUBLE, WDOG_TICK, WDOG_TIMEOUT;
   logic [2:0]       TMR_TICK;
   logic [2:0][15:0] TMR_COUNT;
   logic             RELOAD_REQ, PD_ACTIVE, EXT_IRQ, WAKE, SOFT_RESET;
   logic [2:0][7:0]  PORT_OUT, PORT_OE;
   int               mismatches, check_count;
   logic [7:0]       pa [3] = '{A_PORT3, A_PORT4, A_PORT5};
   logic [7:0]       ma [3] = '{A_DRV3, A_DRV4, A_DRV5};
   logic [7:0]       tl [3] = '{A_T0LO, A_T1LO, A_T2LO};
   logic [7:0]       th [3] = '{A_T0HI, A_T1HI, A_T2HI};

   cpu_special_register_space u_cpu_special_register_space (
      .CORE_CLK(CORE_CLK), .RESET(RESET), .SFR_ADDR(SFR_ADDR),
      .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD),
      .SFR_RDATA(SFR_RDATA), .BIT_ADDR(BIT_ADDR), .BIT_WR(BIT_WR),
      .BIT_WVAL(BIT_WVAL), .BIT_RD(BIT_RD), .BIT_RDATA(BIT_RDATA),
      .ALU_UPD(ALU_UPD), .PTR_INC(PTR_INC), .OPA_OUT(OPA_OUT),
      .OPB_OUT(OPB_OUT), .STAT_OUT(STAT_OUT), .STK_OUT(STK_OUT),
      .AM_REQ(AM_REQ), .AM_RSP(AM_RSP), .SER_RX_DATA(SER_RX_DATA),
      .SER_TX_DATA(SER_TX_DATA), .SER_TX_START(SER_TX_START),
      .RATE_DOUBLE(RATE_DOUBLE), .TMR_TICK(TMR_TICK),
      .WDOG_TICK(WDOG_TICK), .WDOG_TIMEOUT(WDOG_TIMEOUT),
      .TMR_COUNT(TMR_COUNT), .WDOG_COUNT(WDOG_COUNT),
      .RELOAD_REQ(RELOAD_REQ), .PD_ACTIVE(PD_ACTIVE), .EXT_IRQ(EXT_IRQ),
      .WAKE(WAKE), .SOFT_RESET(SOFT_RESET), .PORT1_OUT(PORT1_OUT),
      .PORT_OUT(PORT_OUT), .PORT_OE(PORT_OE));

   // ************************************************************
   // compare and access tasks
   // ************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_sp(input space_e got, input space_e exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      if (mismatches == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge CORE_CLK);
   endtask

   // each access opens with an idle edge: no strobe falls and rises at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1);
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1'b1;
      cyc(1);
      SFR_WR = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      cyc(1);
      SFR_ADDR = a;
      SFR_RD = 1'b1;
      cyc(1);
      SFR_RD = 1'b0;
      chk(SFR_RDATA, exp);
   endtask

   task automatic bw(input logic [7:0] a, input logic v);
      cyc(1);
      BIT_ADDR = a;
      BIT_WVAL = v;
      BIT_WR = 1'b1;
      cyc(1);
      BIT_WR = 1'b0;
   endtask

   task automatic br(input logic [7:0] a, input logic exp);
      cyc(1);
      BIT_ADDR = a;
      BIT_RD = 1'b1;
      cyc(1);
      BIT_RD = 1'b0;
      chk(BIT_RDATA, exp);
   endtask

   task automatic hw(input logic [2:0] t, input logic w, input logic to,
                     input logic inc);
      cyc(1);
      TMR_TICK = t;
      WDOG_TICK = w;
      WDOG_TIMEOUT = to;
      PTR_INC = inc;
      cyc(1);
      {TMR_TICK, WDOG_TICK, WDOG_TIMEOUT, PTR_INC} = '0;
   endtask

   task automatic am(input am_mode_e m, input logic [7:0] f,
                     input logic [7:0] p, input logic [15:0] pc,
                     input logic [15:0] ea, input space_e es);
      cyc(1);
      AM_REQ = '{1'b1, m, f, p, pc};
      cyc(1);
      AM_REQ.valid = 1'b0;
      chk(AM_RSP.valid, 1'b1);
      chk(AM_RSP.addr, ea);
      chk_sp(AM_RSP.space, es);
   endtask

   // ************************************************************
   // clock, hang guard, stimulus
   // ************************************************************
   initial begin
      CORE_CLK = 1'b0;
      forever #5 CORE_CLK = ~CORE_CLK;
   end

   initial begin
      repeat (20000) @(posedge CORE_CLK);
      mismatches++;
      test_done();
   end

   initial begin
      mismatches = 0;
      check_count = 0;
      RESET = 1'b1;
      {SFR_WR, SFR_RD, BIT_WR, BIT_RD, BIT_WVAL, PTR_INC} = '0;
      {SFR_ADDR, SFR_WDATA, BIT_ADDR} = '0;
      {TMR_TICK, WDOG_TICK, WDOG_TIMEOUT, PD_ACTIVE, EXT_IRQ} = '0;
      ALU_UPD = '0;
      AM_REQ = '0;
      SER_RX_DATA = 8'hC3;
      repeat (3) @(posedge CORE_CLK);
      cyc(1);
      RESET = 1'b0;
      chk(STK_OUT, 8'h07);
      chk(PORT_OE[1], 8'h00);
      rd(A_UPORT, 8'hFF);
      wr(A_OPA, 8'h07);
      chk(OPA_OUT, 8'h07);
      chk(STAT_OUT[0], 1'b1);
      rd(A_OPA, 8'h07);
      // hardware load: carry and range set, even parity
      ALU_UPD = '{1'b1, 8'h03, 1'b0, 8'h00, 1'b1, 1'b1, 1'b0, 1'b1};
      cyc(1);
      ALU_UPD = '0;
      chk(STAT_OUT, 8'h84);
      wr(A_STAT, 8'h23);
      chk(STAT_OUT, 8'h22);
      bw(8'hD4, 1'b1);
      am(AM_REG, 8'h05, 8'h00, 16'h0000, 16'h0015, SPC_IRAM);
      bw(8'hD3, 1'b1);
      am(AM_REG, 8'hFF, 8'h00, 16'h0000, 16'h001F, SPC_IRAM);
      br(8'hD5, 1'b1);
      wr(A_OPB, 8'hA5);
      chk(OPB_OUT, 8'hA5);
      rd(A_OPB, 8'hA5);
      bw(8'hE7, 1'b1);
      chk(OPA_OUT, 8'h83);
      chk(STAT_OUT[0], 1'b1);
      am(AM_DIRECT, 8'h7F, 8'h00, 16'h0, 16'h007F, SPC_IRAM);
      am(AM_DIRECT, 8'h80, 8'h00, 16'h0, 16'h0080, SPC_SFR);
      am(AM_IND_RI, 8'h00, 8'h80, 16'h0, 16'h0080, SPC_UPPER);
      am(AM_IND_RI, 8'h00, 8'h7F, 16'h0, 16'h007F, SPC_IRAM);
      am(AM_IMM, 8'h64, 8'h00, 16'h0, 16'h0064, SPC_IMM);
      wr(A_STK, 8'hFF);
      chk(STK_OUT, 8'hFF);
      am(AM_IND_SP, 8'h00, 8'h00, 16'h0, 16'h00FF, SPC_UPPER);
      wr(A_MISC, 8'hDF);
      rd(A_MISC, 8'h19);
      wr(A_PTRLO, 8'h34);
      wr(A_PTRHI, 8'h12);
      wr(A_MISC, 8'h18);
      wr(A_PTRLO, 8'h78);
      wr(A_PTRHI, 8'h56);
      am(AM_EXT_DP, 8'h00, 8'h00, 16'h0, 16'h5678, SPC_XDATA);
      wr(A_MISC, 8'h19);
      rd(A_PTRLO, 8'h34);
      hw(3'b000, 1'b0, 1'b0, 1'b1);
      am(AM_EXT_DP, 8'h00, 8'h00, 16'h0, 16'h1235, SPC_XDATA);
      am(AM_IDX_DP, 8'h00, 8'h00, 16'h0, 16'h12B8, SPC_CODE);
      am(AM_JMP, 8'h00, 8'h00, 16'h0, 16'h12B8, SPC_CODE);
      am(AM_IDX_PC, 8'h00, 8'h00, 16'hFFF0, 16'h0073, SPC_CODE);
      PD_ACTIVE = 1'b1;
      EXT_IRQ = 1'b1;
      cyc(2);
      chk(WAKE, 1'b1);
      wr(A_MISC, 8'h01);
      cyc(1);
      chk(WAKE, 1'b0);
      {PD_ACTIVE, EXT_IRQ} = 2'b00;
      for (int i = 0; i < 3; i++) begin
         wr(pa[i], 8'h0F);
         wr(ma[i], 8'h01);
         cyc(1);
         chk(PORT_OUT[i], 8'h0F);
         chk(PORT_OE[i], 8'hF1);
      end
      wr(A_PORT1, 8'h5A);
      chk(PORT1_OUT, 8'h5A);
      wr(A_UPORT, 8'h9B);
      am(AM_EXT_RI, 8'h00, 8'h44, 16'h0, 16'h9B44, SPC_XDATA);
      rd(A_SERBUF, 8'hC3);
      wr(A_SERBUF, 8'h55);
      chk(SER_TX_START, 1'b1);
      chk(SER_TX_DATA, 8'h55);
      cyc(1);
      chk(SER_TX_START, 1'b0);
      for (int i = 0; i < 3; i++) begin
         wr(th[i], 8'(i + 1));
         wr(tl[i], 8'hFF);
         hw(3'b001 << i, 1'b0, 1'b0, 1'b0);
         chk(TMR_COUNT[i], 16'((i + 2) << 8));
      end
      wr(A_WDOG, 8'hFE);
      hw(3'b000, 1'b1, 1'b0, 1'b0);
      chk(WDOG_COUNT, 8'hFF);
      rd(A_WDOG, 8'hFF);
      rd(8'h84, 8'h00);
      wr(A_BOOT, 8'h04);
      chk(RELOAD_REQ, 1'b1);
      rd(A_BOOT, 8'h00);
      chk(RELOAD_REQ, 1'b0);
      wr(A_BOOT, 8'h03);
      chk(RATE_DOUBLE, 1'b1);
      rd(A_BOOT, 8'h03);
      hw(3'b000, 1'b0, 1'b1, 1'b0);
      chk(RELOAD_REQ, 1'b1);
      wr(A_BOOT, 8'h01);
      hw(3'b000, 1'b0, 1'b1, 1'b0);
      chk(RELOAD_REQ, 1'b0);
      wr(A_BOOT, 8'h00);
      chk(RATE_DOUBLE, 1'b0);
      // soft reset lands one edge after its pulse
      wr(A_MISC, 8'h20);
      chk(SOFT_RESET, 1'b1);
      cyc(1);
      chk(STK_OUT, 8'h07);
      chk(OPA_OUT, 8'h00);
      chk(PORT1_OUT, 8'hFF);
      test_done();
   end

endmodule // tb_top
